// ---- spsc_cfg.svh ----
// Constants for the serial port switch configuration block
`ifndef SPSC_CFG_SVH
`define SPSC_CFG_SVH
// Input synchroniser depth
`define SPSC_SYNC_STAGES 3
// Switch bank widths and current sample width
`define SPSC_ADDR_W 8
`define SPSC_COMM_W 8
`define SPSC_CUR_W 16
// Communication switch positions
`define SPSC_SW_BAUD_LO 0
`define SPSC_SW_PAR_EN 3
`define SPSC_SW_PAR_EVEN 4
`define SPSC_SW_REVERSE 5
// Factory address switch setting
`define SPSC_ADDR_DEFAULT 8'h01
// Bit rates in bit/s
`define SPSC_BAUD_1200 32'd1200
`define SPSC_BAUD_2400 32'd2400
`define SPSC_BAUD_4800 32'd4800
`define SPSC_BAUD_9600 32'd9600
`define SPSC_BAUD_19200 32'd19200
`define SPSC_BAUD_38400 32'd38400
// Core clock rate in Hz
`define SPSC_CLK_HZ 32'd250000000
// Cycles per bit, derived from clock rate and bit rate (rounded down)
`define SPSC_DIV(b) (`SPSC_CLK_HZ / (b))
// Final settle count (nine settle cycles, 0 to 8) after reset before the configuration is declared valid
`define SPSC_SETTLE_CYC 4'd8
`endif

// ---- spsc_pkg.sv ----
// Types for the serial port switch configuration block
package spsc_pkg;
	typedef enum logic [2:0] {SPSC_B1200, SPSC_B2400, SPSC_B4800, SPSC_B9600,
		SPSC_B19200, SPSC_B38400, SPSC_BBAD} spsc_baud_t;
	typedef enum logic [1:0] {SPSC_PAR_NONE, SPSC_PAR_ODD, SPSC_PAR_EVEN} spsc_par_t;
	typedef enum logic [1:0] {SPSC_ST_RESET, SPSC_ST_SETTLE, SPSC_ST_RUN} spsc_state_t;
endpackage

// ---- spsc_top.sv ----
// Serial port switch configuration: address, rate, parity and current polarity
`timescale 1ns/1ns
`include "spsc_cfg.svh"
module spsc_top
	import spsc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] addr_sw,
	input wire logic [7:0] comm_sw,
	input wire logic [15:0] cfg_reg_val,
	input wire logic cfg_reg_wr,
	input wire logic signed [15:0] cur_raw,
	input wire logic cur_valid,
	input wire logic frame_done,
	input wire logic frame_usable,
	output logic [7:0] slave_addr,
	output logic [2:0] baud_sel,
	output logic [31:0] bit_div,
	output logic [1:0] parity_mode,
	output logic cfg_ready,
	output logic signed [15:0] cur_report,
	output logic cur_report_valid,
	output logic diag_event,
	output logic rx_ok,
	output logic rx_error
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Rate decode; unlisted combinations give SPSC_BBAD, which baud_div maps to the slowest rate
	function automatic spsc_baud_t baud_decode(input logic [2:0] s);
		spsc_baud_t b;
		b = SPSC_BBAD;
		case (s)
			3'h0: b = SPSC_B1200;
			3'h1: b = SPSC_B2400;
			3'h2: b = SPSC_B4800;
			3'h3: b = SPSC_B9600;
			3'h4: b = SPSC_B19200;
			3'h5: b = SPSC_B38400;
			default: b = SPSC_BBAD;
		endcase
		return b;
	endfunction

	function automatic logic [31:0] baud_div(input spsc_baud_t b);
		logic [31:0] d;
		d = `SPSC_DIV(`SPSC_BAUD_1200);
		case (b)
			SPSC_B2400: d = `SPSC_DIV(`SPSC_BAUD_2400);
			SPSC_B4800: d = `SPSC_DIV(`SPSC_BAUD_4800);
			SPSC_B9600: d = `SPSC_DIV(`SPSC_BAUD_9600);
			SPSC_B19200: d = `SPSC_DIV(`SPSC_BAUD_19200);
			SPSC_B38400: d = `SPSC_DIV(`SPSC_BAUD_38400);
			default: d = `SPSC_DIV(`SPSC_BAUD_1200);
		endcase
		return d;
	endfunction

	// ----------------------------------------------------------------
	// Switch synchronisers
	// ----------------------------------------------------------------

	// Three stages; a change counts once stages two and three agree
	logic [7:0] asw_s1_q, asw_s2_q, asw_s3_q, asw_stable_q;
	logic [7:0] csw_s1_q, csw_s2_q, csw_s3_q, csw_stable_q;
	always_ff @(posedge core_clk)
	begin
		asw_s1_q <= addr_sw;
		asw_s2_q <= asw_s1_q;
		asw_s3_q <= asw_s2_q;
		csw_s1_q <= comm_sw;
		csw_s2_q <= csw_s1_q;
		csw_s3_q <= csw_s2_q;
	end

	// Stable copies only move when two stages agree, so a bounce is filtered
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			asw_stable_q <= `SPSC_ADDR_DEFAULT;
			csw_stable_q <= 8'h00;
		end
		else
		begin
			asw_stable_q <= (asw_s2_q == asw_s3_q) ? asw_s3_q : asw_stable_q;
			csw_stable_q <= (csw_s2_q == csw_s3_q) ? csw_s3_q : csw_stable_q;
		end
	end

	// ----------------------------------------------------------------
	// Startup sequencer
	// ----------------------------------------------------------------

	// Settle time covers the synchroniser latency before switches are trusted
	spsc_state_t state_q, state_d;
	logic [3:0] settle_q, settle_d;
	always_comb
	begin
		state_d = state_q;
		settle_d = settle_q;
		case (state_q)
			SPSC_ST_RESET:
			begin
				state_d = SPSC_ST_SETTLE;
				settle_d = 4'h0;
			end
			SPSC_ST_SETTLE:
			begin
				settle_d = settle_q + 4'h1;
				if (settle_q == `SPSC_SETTLE_CYC)
					state_d = SPSC_ST_RUN;
			end
			default: state_d = SPSC_ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_q <= SPSC_ST_RESET;
			settle_q <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			settle_q <= settle_d;
		end
	end

	wire logic running = (state_q == SPSC_ST_RUN);

	// ----------------------------------------------------------------
	// Serial configuration decode
	// ----------------------------------------------------------------

	// Address, rate and parity leave this block; switch 5 sets current polarity, switches 6 and 7 are unused
	wire spsc_baud_t baud_w = baud_decode(csw_stable_q[2:0]);
	wire logic par_en_w = csw_stable_q[`SPSC_SW_PAR_EN];
	wire logic par_even_w = csw_stable_q[`SPSC_SW_PAR_EVEN];
	wire spsc_par_t par_w = !par_en_w ? SPSC_PAR_NONE :
		(par_even_w ? SPSC_PAR_EVEN : SPSC_PAR_ODD);
	// Each switch k is worth 2**k, so the sum is the switch word itself
	wire logic [7:0] addr_w = asw_stable_q;

	// Outputs are frozen until settled, then track the switches
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			slave_addr <= `SPSC_ADDR_DEFAULT;
			baud_sel <= 3'h0;
			bit_div <= `SPSC_DIV(`SPSC_BAUD_1200);
			parity_mode <= 2'h0;
			cfg_ready <= 1'b0;
		end
		else if (running)
		begin
			slave_addr <= addr_w;
			baud_sel <= baud_w;
			bit_div <= baud_div(baud_w);
			parity_mode <= par_w;
			cfg_ready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Current polarity
	// ----------------------------------------------------------------

	// Nonzero written value overrides the switch; zero hands control back
	logic [15:0] sys_cfg_q;
	always_ff @(posedge core_clk)
	begin
		if (rst)
			sys_cfg_q <= 16'h0000;
		else if (cfg_reg_wr)
			sys_cfg_q <= cfg_reg_val;
	end

	wire logic override_w = (sys_cfg_q != 16'h0000);
	wire logic invert_w = override_w ? sys_cfg_q[0] : csw_stable_q[`SPSC_SW_REVERSE];
	// Negating the most negative value saturates rather than wrapping
	wire logic signed [15:0] cur_neg_w = (cur_raw == 16'sh8000) ? 16'sh7FFF : -cur_raw;
	wire logic signed [15:0] cur_pol_w = invert_w ? cur_neg_w : cur_raw;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cur_report <= 16'sh0000;
			cur_report_valid <= 1'b0;
			diag_event <= 1'b0;
		end
		else
		begin
			cur_report_valid <= cur_valid;
			if (cur_valid)
			begin
				cur_report <= cur_pol_w;
				diag_event <= cur_pol_w[15];
			end
		end
	end

	// ----------------------------------------------------------------
	// Frame status
	// ----------------------------------------------------------------

	// Frames before the configuration is applied count as unusable
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rx_ok <= 1'b0;
			rx_error <= 1'b0;
		end
		else
		begin
			rx_ok <= frame_done && frame_usable && cfg_ready;
			rx_error <= frame_done && !(frame_usable && cfg_ready);
		end
	end

endmodule

// ---- spsc_chk_assertions.sv ----
// Port checker for the switch configuration block
`timescale 1ns/1ns
module spsc_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cur_valid,
	input wire logic frame_done,
	input wire logic frame_usable,
	input wire logic [31:0] bit_div,
	input wire logic [2:0] baud_sel,
	input wire logic [1:0] parity_mode,
	input wire logic cfg_ready,
	input wire logic signed [15:0] cur_report,
	input wire logic cur_report_valid,
	input wire logic diag_event,
	input wire logic rx_ok,
	input wire logic rx_error
);
	// ----
	// Properties
	// ----
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_cur; cur_valid |=> cur_report_valid; endproperty
	a_cur: assert property (p_cur) else $error("no current report");
	property p_diag; cur_report_valid |-> diag_event == cur_report[15]; endproperty
	a_diag: assert property (p_diag) else $error("event flag off sign");
	property p_bad; frame_done && !frame_usable |=> rx_error && !rx_ok; endproperty
	a_bad: assert property (p_bad) else $error("bad frame not flagged");
	property p_good; frame_done && frame_usable && cfg_ready |=> rx_ok; endproperty
	a_good: assert property (p_good) else $error("good frame lost");
	property p_one; rx_ok |-> $past(frame_done); endproperty
	a_one: assert property (p_one) else $error("stray ok pulse");
	property p_par; parity_mode != 2'h3; endproperty
	a_par: assert property (p_par) else $error("parity code 3");
	property p_div; cfg_ready && baud_sel == 3'h5 |-> bit_div == 32'd6510; endproperty
	a_div: assert property (p_div) else $error("fast rate divider");
	// Nothing is accepted before the switches are applied
	property p_early; !cfg_ready |-> !rx_ok; endproperty
	a_early: assert property (p_early) else $error("ok before ready");
	c_bad: cover property (frame_done && !frame_usable);
	c_neg: cover property (cur_report_valid && diag_event);
	c_fast: cover property (cfg_ready && baud_sel == 3'h5);
endmodule
bind spsc_top spsc_chk u_chk (.*);

// ---- spsc_master.sv ----
// Modbus RTU master model ending frames at the slave
`timescale 1ns/1ns
module spsc_master (
	input wire logic core_clk,
	input wire logic req,
	input wire logic bad,
	output logic frame_done,
	output logic frame_usable
);
	// ----
	// Frame ends
	// ----
	// Lone slave on this bus, so its address is unique and in range
	localparam int SLAVES = 1;
	initial frame_done = 1'b0;
	initial frame_usable = 1'b0;
	// Idle qualifier flips so a held level is never trusted
	always @(posedge core_clk)
	begin
		frame_done <= req;
		frame_usable <= req ? !bad : !frame_usable;
	end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the switch configuration block
`timescale 1ns/1ns
module testbench
	import spsc_pkg::*;
;
	logic core_clk = 1'b0, rst = 1'b1, cfg_reg_wr = 1'b0, cur_valid = 1'b0;
	logic req = 1'b0, bad = 1'b0, frame_done, frame_usable, cfg_ready;
	logic cur_report_valid, diag_event, rx_ok, rx_error;
	logic [7:0] addr_sw = 8'h01, comm_sw = 8'h00, slave_addr;
	logic [15:0] cfg_reg_val = 16'h0000, sys_q = 16'h0000;
	logic signed [15:0] cur_raw = 16'h0000, cur_report;
	logic [2:0] baud_sel;
	logic [31:0] bit_div;
	logic [1:0] parity_mode;
	logic [16:0] cq[$];
	logic [1:0] fq[$];
	int fail_count = 0, tests_run = 0;
	int rates[6] = '{1200, 2400, 4800, 9600, 19200, 38400};
	// ----
	// Harness
	// ----
	initial forever #2 core_clk = ~core_clk;
	spsc_top u_spsc_top (
		.core_clk(core_clk),
		.rst(rst),
		.addr_sw(addr_sw),
		.comm_sw(comm_sw),
		.cfg_reg_val(cfg_reg_val),
		.cfg_reg_wr(cfg_reg_wr),
		.cur_raw(cur_raw),
		.cur_valid(cur_valid),
		.frame_done(frame_done),
		.frame_usable(frame_usable),
		.slave_addr(slave_addr),
		.baud_sel(baud_sel),
		.bit_div(bit_div),
		.parity_mode(parity_mode),
		.cfg_ready(cfg_ready),
		.cur_report(cur_report),
		.cur_report_valid(cur_report_valid),
		.diag_event(diag_event),
		.rx_ok(rx_ok),
		.rx_error(rx_error)
	);
	spsc_master u_spsc_master (
		.core_clk(core_clk),
		.req(req),
		.bad(bad),
		.frame_done(frame_done),
		.frame_usable(frame_usable)
	);
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Sample with its expected sign noted; the extra cycle keeps strobes apart
	task cur(input logic signed [15:0] v);
		logic signed [15:0] e;
		logic inv;
		inv = (sys_q != 16'h0000) ? sys_q[0] : comm_sw[5];
		e = inv ? -v : v;
		// Only an inverted most negative sample saturates
		if (inv && v == 16'sh8000) e = 16'sh7FFF;
		cq.push_back({e[15], e});
		cur_raw <= v;
		cur_valid <= 1'b1;
		tick(1);
		cur_valid <= 1'b0;
		tick(1);
	endtask
	task frame(input logic b, input logic ok);
		fq.push_back({ok, !ok});
		req <= 1'b1;
		bad <= b;
		tick(1);
		req <= 1'b0;
		tick(1);
	endtask
	task wr(input logic [15:0] v);
		sys_q = v;
		cfg_reg_val <= v;
		cfg_reg_wr <= 1'b1;
		tick(1);
		cfg_reg_wr <= 1'b0;
		tick(1);
	endtask
	// Results are compared oldest first as they appear
	always @(posedge core_clk)
	begin
		if (cur_report_valid === 1'b1)
			check({diag_event, cur_report}, cq.pop_front());
		if ((rx_ok | rx_error) === 1'b1)
			check({rx_ok, rx_error}, fq.pop_front());
	end
	// Hang guard, far beyond the few hundred cycles the run needs
	initial
	begin
		tick(3000);
		fail_count++;
		test_done();
	end
	initial
	begin
		logic [7:0] a;
		int r, p;
		void'($urandom(32'h83D8));
		tick(20);
		rst <= 1'b0;
		frame(1'b0, 1'b0);
		check(cfg_ready, 1'b0);
		for (int i = 0; i < 40 && cfg_ready !== 1'b1; i++) tick(1);
		check(cfg_ready, 1'b1);
		check(slave_addr, 8'h01);
		for (int i = 0; i < 18; i++)
		begin
			a = 8'($urandom);
			r = i % 6;
			p = i / 6;
			addr_sw <= a;
			comm_sw <= {a[7:6], 1'b0, p == 2 || (p == 0 && a[0]), p != 0, r[2:0]};
			tick(8);
			check(slave_addr, a);
			check(baud_sel, r);
			check(bit_div, 250000000 / rates[r]);
			check(parity_mode, p);
		end
		// Unlisted rate code falls back to the slowest rate
		comm_sw <= 8'h07;
		tick(8);
		check(baud_sel, 3'h6);
		check(bit_div, 250000000 / 1200);
		check(parity_mode, 2'h0);
		// Switch alone, override both ways, then override cleared
		for (int i = 0; i < 6; i++)
		begin
			comm_sw[5] <= i inside {1, 3, 4};
			tick(8);
			wr(i == 2 ? 16'h0001 : i == 3 ? 16'h0002 : 16'h0000);
			cur(16'($urandom));
			cur(16'h8000);
		end
		frame(1'b0, 1'b1);
		frame(1'b1, 1'b0);
		tick(4);
		check(cq.size() + fq.size(), 0);
		test_done();
	end
endmodule
